// ==== design/esp_host_port.sv ====
// Serial host port: 3/4-wire receive and read-back
`include "esp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module esp_host_port
  import esp_pkg::*;
#(
  parameter int READ_BYTES = 2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Strap
  input  wire logic       interface_width_select,
  // Serial link pins
  input  wire logic       sclPin,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       csN,
  input  wire logic       dcPin,
  // Received bytes
  output esp_byte_t       rxByte,
  output logic            rxValid,
  output logic            rxIsCmd,
  // Read-back source
  output logic [7:0]      readAddr,
  output logic [3:0]      readIndex,
  output logic            readReq,
  input  wire logic [7:0] readData
);
  esp_pins_t  rawPins;
  esp_pins_t  pins;
  esp_state_t state;
  logic       sclLast;
  logic       threeWire;
  logic [3:0] bitCnt;
  logic [8:0] shift;
  logic [7:0] outByte;
  logic [2:0] outCnt;
  logic       addrSeen;
  logic       rise;
  logic       fall;
  logic       widthSync1;
  logic       widthSync2;

  assign rawPins = '{clkPin: sclPin, dataIn: sdaIn, selectN: csN, cmdData: dcPin};

  // All pins cross into the clk domain first
  esp_sync #(.WIDTH(4)) u_sync (
    .clk    (clk),
    .rst    (rst),
    .async  (rawPins),
    .synced (pins)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      widthSync1 <= 1'b0;
      widthSync2 <= 1'b0;
    end else begin
      widthSync1 <= interface_width_select;
      widthSync2 <= widthSync1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      threeWire <= 1'b0;
    else if (pins.selectN)
      threeWire <= widthSync2;
  end

  always_ff @(posedge clk) begin
    if (rst)
      sclLast <= 1'b1;
    else
      sclLast <= pins.clkPin;
  end

  assign rise = !pins.selectN && pins.clkPin && !sclLast;
  assign fall = !pins.selectN && !pins.clkPin && sclLast;

  logic enterRead4;
  // Command/data high at the fall closing the address
  assign enterRead4 = fall && !threeWire && addrSeen && pins.cmdData
                      && state == ST_SHIFT && bitCnt == 4'h0;

  always_ff @(posedge clk) begin
    if (rst || pins.selectN) begin
      state  <= ST_IDLE;
      bitCnt <= `ESP_BITCNT_RESET;
    end else if (rise) begin
      case (state)
        ST_IDLE, ST_SHIFT: begin
          if (bitCnt == (threeWire ? `ESP_WORD3_BITS : `ESP_BYTE_BITS) - 4'h1) begin
            bitCnt <= `ESP_BITCNT_RESET;
            state  <= ST_SHIFT;
          end else begin
            bitCnt <= bitCnt + 4'h1;
            state  <= ST_SHIFT;
          end
        end
        // Single flag bit then read data
        ST_FLAG: state <= ST_READ;
        ST_READ: state <= ST_READ;
        default: state <= ST_IDLE;
      endcase
      // Lone 1 flag after the address; data follows at the next fall
      // Limitation: a data word after a command in one selection reads as a read
      if (threeWire && addrSeen && state != ST_READ && bitCnt == 4'h0 && sdaBit())
        state <= ST_READ;
    end else if (enterRead4) begin
      state <= ST_READ;
    end
  end

  function automatic logic sdaBit();
    return pins.dataIn;
  endfunction

  // MSB first into the shift register
  // Flag bit then D7 down to D0
  always_ff @(posedge clk) begin
    if (rst)
      shift <= 9'h000;
    else if (rise && state != ST_READ && state != ST_FLAG)
      shift <= {shift[7:0], pins.dataIn};
  end

  logic byteDone;
  assign byteDone = rise && state != ST_READ && state != ST_FLAG
                    && bitCnt == (threeWire ? `ESP_WORD3_BITS : `ESP_BYTE_BITS) - 4'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxByte  <= '0;
      rxValid <= 1'b0;
      rxIsCmd <= 1'b0;
    end else begin
      rxValid <= byteDone;
      if (byteDone) begin
        rxByte.value  <= {shift[6:0], pins.dataIn};
        rxByte.isData <= threeWire ? shift[7] : pins.cmdData;
        rxIsCmd       <= threeWire ? !shift[7] : !pins.cmdData;
      end
    end
  end

  // Last command byte is the read address
  always_ff @(posedge clk) begin
    if (rst || pins.selectN) begin
      addrSeen <= 1'b0;
      readAddr <= readAddr;
    end else if (byteDone) begin
      addrSeen <= threeWire ? !shift[7] : !pins.cmdData;
      if (threeWire ? !shift[7] : !pins.cmdData)
        readAddr <= {shift[6:0], pins.dataIn};
    end
  end

  // Shift out on falling edges, MSB first
  always_ff @(posedge clk) begin
    if (rst || pins.selectN) begin
      outByte   <= 8'h00;
      outCnt    <= 3'h0;
      readIndex <= 4'h0;
      readReq   <= 1'b0;
    end else begin
      readReq <= 1'b0;
      if ((state == ST_READ && fall) || enterRead4) begin
        if (outCnt == 3'h0) begin
          outByte   <= {readData[6:0], 1'b0};
          readIndex <= (readIndex == 4'(READ_BYTES - 1)) ? readIndex : readIndex + 4'h1;
          readReq   <= 1'b1;
        end else begin
          outByte <= {outByte[6:0], 1'b0};
        end
        outCnt <= outCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || pins.selectN) begin
      sdaOut <= 1'b0;
      sdaOe  <= 1'b0;
    end else if ((state == ST_READ && fall) || enterRead4) begin
      sdaOe  <= 1'b1;
      sdaOut <= (outCnt == 3'h0) ? readData[7] : outByte[7];
    end
  end
endmodule // esp_host_port
`default_nettype wire

// ==== design/esp_cfg.svh ====
// Constants of the serial host port
// How it works
// - Select low: 4-wire with command/data line
// - Select high: 3-wire, 9-bit words
// - 4-wire: sample rising edges, MSB first
// - Route finished byte by command/data level
// - Drive read byte on falling edges, MSB
// - Several read bytes per selection allowed
// - Deselect ends read; stop driving data
// - 3-wire write: flag then D7..D0
// - Flag 0 command, flag 1 data
`ifndef ESP_CFG_SVH
`define ESP_CFG_SVH
`define ESP_BYTE_BITS     4'h8
`define ESP_WORD3_BITS    4'h9
`define ESP_SYNC_RESET    3'h7
`define ESP_BITCNT_RESET  4'h0
`define ESP_READ_BYTES    4'h2
`define ESP_SCL_WRITE_MHZ 20
`define ESP_SCL_READ_KHZ  2500
`endif

// ==== design/esp_pkg.sv ====
// Types of the serial host port
package esp_pkg;
  typedef struct packed {
    logic       isData;
    logic [7:0] value;
  } esp_byte_t;
  typedef struct packed {
    logic       clkPin;
    logic       dataIn;
    logic       selectN;
    logic       cmdData;
  } esp_pins_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_FLAG  = 4'b0100,
    ST_READ  = 4'b1000
  } esp_state_t;
endpackage : esp_pkg

// ==== design/esp_sync.sv ====
// Two-stage synchroniser for the link pins
`include "esp_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module esp_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pins
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;
  // Reset as deselected, clock low, data and command/data high
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= WIDTH'({1'b0, `ESP_SYNC_RESET});
      synced <= WIDTH'({1'b0, `ESP_SYNC_RESET});
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule // esp_sync
`default_nettype wire

// ==== verif/esp_host_port_sva.sv ====
// Pin-level assertions for the serial host port
`timescale 1ns/10ps
`default_nettype none
module esp_host_port_sva
  import esp_pkg::*;
(
  // Clock and reset
  input wire logic      clk,
  input wire logic      rst,
  // Link
  input wire logic      sclPin,
  input wire logic      csN,
  input wire logic      sdaOut,
  input wire logic      sdaOe,
  // User side
  input wire logic      rxValid,
  input wire logic      rxIsCmd,
  input wire esp_byte_t rxByte,
  input wire logic      readReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Five cycles covers the pin synchroniser plus the output flop
  a_oe_release: assert property (csN [*5] |-> !sdaOe)
    else $error("data driven while deselected");
  a_quiet_idle: assert property (csN [*5] |-> !rxValid && !readReq)
    else $error("activity while deselected");
  a_rx_pulse: assert property (rxValid |=> !rxValid)
    else $error("byte strobe too long");
  a_kind_match: assert property (rxValid |-> rxIsCmd != rxByte.isData)
    else $error("command and data flags disagree");
  a_rx_on_high: assert property (rxValid |-> sclPin && !csN)
    else $error("byte outside a rising clock phase");
  a_req_pulse: assert property (readReq |=> !readReq)
    else $error("fetch strobe too long");
  a_bit_on_low: assert property (sdaOe && $changed(sdaOut) |-> !sclPin)
    else $error("read bit changed in high phase");
  a_reset_clear: assert property ($fell(rst) |-> !rxValid && !sdaOe && !readReq)
    else $error("outputs busy after reset");
  c_cmd: cover property (rxValid && rxIsCmd);
  c_data: cover property (rxValid && rxByte.isData);
  c_read: cover property (sdaOe ##1 !sdaOe);
endmodule // esp_host_port_sva
bind esp_host_port esp_host_port_sva i_esp_host_port_sva (.clk(clk), .rst(rst),
  .sclPin(sclPin), .csN(csN), .sdaOut(sdaOut), .sdaOe(sdaOe), .rxValid(rxValid),
  .rxIsCmd(rxIsCmd), .rxByte(rxByte), .readReq(readReq));
`default_nettype wire

// ==== verif/esp_host_model.sv ====
// Host microcontroller model driving the serial link
`timescale 1ns/10ps
`default_nettype none
module esp_host_model (
  // Clock
  input  wire logic clk,
  // Link
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sda,
  output logic      csN,
  output logic      dc
);
  initial begin
    scl = 1'b0;
    sda = 1'b0;
    csN = 1'b1;
    dc  = 1'b0;
  end
  // Released data line shows the inverse so stale values never match
  task frame(input logic on);
    repeat (6) @(posedge clk);
    csN <= !on;
    sda <= ~sda;
    repeat (6) @(posedge clk);
  endtask
  // dc held per word, 17-cycle (about 588 kHz) clock
  // dcEnd goes out with the last falling clock edge
  task shift(input int n, input logic [8:0] v, input logic dcv, input logic dcEnd,
             output logic [8:0] got);
    got = 9'h000;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk) sda <= v[i];
      dc <= dcv;
      repeat (8) @(posedge clk);
      scl <= 1'b1;
      got[i] = sdaLine;
      repeat (8) @(posedge clk);
      scl <= 1'b0;
      if (i == 0) dc <= dcEnd;
    end
  endtask
endmodule // esp_host_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench of the serial host port
`timescale 1ns/10ps
`default_nettype none
module tb;
  import esp_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wideSel = 1'b0;
  logic       sdaOut, sdaOe, scl, sda, csN, dc, rxValid, rxIsCmd, readReq;
  esp_byte_t  rxByte;
  logic [7:0] readAddr;
  logic [3:0] readIndex;
  logic [9:0] rxLast;
  logic [8:0] got;
  int         err_total = 0;
  int         compares = 0;
  int         reqs = 0;
  int         reqBase = 0;
  wire logic       sdaLine = sdaOe ? sdaOut : sda;
  wire logic [7:0] readData = ~readAddr ^ {4'h0, readIndex};
  always #50 clk = ~clk;
  esp_host_port #(.READ_BYTES(2)) i_esp_host_port (.clk(clk), .rst(rst),
    .interface_width_select(wideSel), .sclPin(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .csN(csN), .dcPin(dc), .rxByte(rxByte), .rxValid(rxValid),
    .rxIsCmd(rxIsCmd), .readAddr(readAddr), .readIndex(readIndex), .readReq(readReq),
    .readData(readData));
  esp_host_model i_esp_host_model (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sda(sda),
    .csN(csN), .dc(dc));
  always @(posedge clk) if (rxValid === 1'b1) rxLast <= {rxIsCmd, rxByte};
  always @(posedge clk) if (readReq === 1'b1) reqs <= reqs + 1;
  task chk(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_write4;
    i_esp_host_model.frame(1'b1);
    i_esp_host_model.shift(4, 9'h00F, 1'b0, 1'b0, got);
    i_esp_host_model.frame(1'b0);
    i_esp_host_model.frame(1'b1);
    i_esp_host_model.shift(8, 9'h03C, 1'b0, 1'b0, got);
    chk(rxLast, 10'h23C);
    i_esp_host_model.shift(8, 9'h0C3, 1'b1, 1'b1, got);
    chk(rxLast, 10'h1C3);
    i_esp_host_model.frame(1'b0);
  endtask
  task t_read(input int flagBits);
    reqBase = reqs;
    i_esp_host_model.frame(1'b1);
    i_esp_host_model.shift(8 + flagBits, 9'h02E, 1'b0, !flagBits[0], got);
    i_esp_host_model.shift(8 + flagBits, {flagBits[0], 8'h00}, !flagBits[0],
                           !flagBits[0], got);
    chk({2'h0, got[7:0]}, 10'h0D1);
    i_esp_host_model.shift(8, 9'h000, !flagBits[0], !flagBits[0], got);
    chk({2'h0, got[7:0]}, 10'h0D0);
    chk({6'h00, readIndex}, 10'h001);
    chk(10'(reqs - reqBase), 10'h002);
    i_esp_host_model.frame(1'b0);
    chk({9'h000, sdaOe}, 10'h000);
  endtask
  task t_write3;
    @(posedge clk) wideSel <= 1'b1;
    i_esp_host_model.frame(1'b1);
    i_esp_host_model.shift(9, 9'h05A, 1'b0, 1'b0, got);
    chk(rxLast, 10'h25A);
    // Data word in a new selection, so its flag is not a read turn-around
    i_esp_host_model.frame(1'b0);
    i_esp_host_model.frame(1'b1);
    i_esp_host_model.shift(9, 9'h1A5, 1'b0, 1'b0, got);
    chk(rxLast, 10'h1A5);
    i_esp_host_model.frame(1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_write4;
    t_read(0);
    t_write3;
    t_read(1);
    give_verdict;
  end
  // Whole run needs well under a millisecond
  initial begin
    #2000000;
    err_total++;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
